// ==== rtl/acd_top.sv ====
`timescale 1ns/10ps
module acd_top
  import acd_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [DATA_W-1:0]        reg_rdata,
  input  wire logic                mod_bit0,
  input  wire logic                mod_bit1,
  output logic                     modulator_clk,
  output logic                     sample_clk,
  output logic                     result_rate_clk,
  output logic                     result_ready_n,
  output logic                     irq
);
  // ****************************************
  // registers
  // ****************************************
  logic [1:0]        pre_r;
  logic [2:0]        osr_r;
  logic [EVT_W-1:0]  stat_r;
  logic [EVT_W-1:0]  mask_r;
  logic [TRIM_W-1:0] offt0_r;
  logic [TRIM_W-1:0] offt1_r;
  logic [TRIM_W-1:0] slope0_r;
  logic [TRIM_W-1:0] slope1_r;
  logic [TRIM_W-1:0] res0;
  logic [TRIM_W-1:0] res1;
  logic              sat0;
  logic              sat1;
  logic              ready_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [EVT_W-1:0]  evt;
  logic [3:0]        pre_lim;
  logic [OSR_CNT_W-1:0] osr_lim;
  logic [4:0]        shift;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pre_r <= PRE_RST;
      osr_r <= OSR_RST;
    end else if (reg_wr && reg_addr == CFG_OFS) begin
      pre_r <= reg_wdata[PRE_LSB +: 2];
      osr_r <= reg_wdata[OSR_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mask_r <= '0;
    end else if (reg_wr && reg_addr == MASK_OFS) begin
      mask_r <= reg_wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      offt0_r  <= '0;
      offt1_r  <= '0;
      slope0_r <= '0;
      slope1_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == OFFT0_OFS) begin
        offt0_r <= reg_wdata[TRIM_W-1:0];
      end else if (reg_addr == OFFT1_OFS) begin
        offt1_r <= reg_wdata[TRIM_W-1:0];
      end else if (reg_addr == SLOPE0_OFS) begin
        slope0_r <= reg_wdata[TRIM_W-1:0];
      end else if (reg_addr == SLOPE1_OFS) begin
        slope1_r <= reg_wdata[TRIM_W-1:0];
      end
    end
  end

  // ****************************************
  // clock chain as enables
  // ****************************************
  assign pre_lim = 4'((4'h1 << pre_r) - 4'h1);
  assign osr_lim = OSR_CNT_W'((13'h0020 << osr_r) - 13'h0001);

  acd_div #(.W(4)) u_pre (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .en_in   (1'b1),
    .limit   (pre_lim),
    .tick    (modulator_clk)
  );

  acd_div #(.W(2)) u_smp (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .en_in   (modulator_clk),
    .limit   (SAMPLE_DIV_M1),
    .tick    (sample_clk)
  );

  acd_div #(.W(OSR_CNT_W)) u_osr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .en_in   (sample_clk),
    .limit   (osr_lim),
    .tick    (result_rate_clk)
  );

  // ****************************************
  // decimation and trims per channel
  // ****************************************
  // wider ratios need less left shift to reach full scale
  assign shift = OSR_MIN_SHIFT - {2'h0, osr_r};

  acd_trim u_ch0 (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .sample_en (sample_clk),
    .dump      (result_rate_clk),
    .bit_in    (mod_bit0),
    .shift     (shift),
    .offset    (offt0_r),
    .slope     (slope0_r),
    .result_r  (res0),
    .sat_r     (sat0)
  );

  acd_trim u_ch1 (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .sample_en (sample_clk),
    .dump      (result_rate_clk),
    .bit_in    (mod_bit1),
    .shift     (shift),
    .offset    (offt1_r),
    .slope     (slope1_r),
    .result_r  (res1),
    .sat_r     (sat1)
  );

  // ****************************************
  // ready pulse
  // ****************************************
  // low from the result edge to the next sample edge: one sample period
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ready_r <= 1'b0;
    end else if (sample_clk) begin
      ready_r <= result_rate_clk;
    end
  end

  assign result_ready_n = ~ready_r;

  // ****************************************
  // interrupt status
  // ****************************************
  assign evt[EVT_READY] = sample_clk && result_rate_clk;
  assign evt[EVT_SAT]   = sat0 || sat1;

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stat_r <= '0;
    end else if (reg_wr && reg_addr == STAT_OFS) begin
      stat_r <= (stat_r & ~reg_wdata[EVT_W-1:0]) | evt;
    end else begin
      stat_r <= stat_r | evt;
    end
  end

  assign irq = |(stat_r & mask_r);

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    rdata_nxt = '0;
    if (reg_addr == CFG_OFS) begin
      rdata_nxt[PRE_LSB +: 2] = pre_r;
      rdata_nxt[OSR_LSB +: 3] = osr_r;
    end else if (reg_addr == STAT_OFS) begin
      rdata_nxt[EVT_W-1:0] = stat_r;
    end else if (reg_addr == MASK_OFS) begin
      rdata_nxt[EVT_W-1:0] = mask_r;
    end else if (reg_addr == OFFT0_OFS) begin
      rdata_nxt[TRIM_W-1:0] = offt0_r;
    end else if (reg_addr == SLOPE0_OFS) begin
      rdata_nxt[TRIM_W-1:0] = slope0_r;
    end else if (reg_addr == OFFT1_OFS) begin
      rdata_nxt[TRIM_W-1:0] = offt1_r;
    end else if (reg_addr == SLOPE1_OFS) begin
      rdata_nxt[TRIM_W-1:0] = slope1_r;
    end else if (reg_addr == RES0_OFS) begin
      rdata_nxt[TRIM_W-1:0] = res0;
    end else if (reg_addr == RES1_OFS) begin
      rdata_nxt[TRIM_W-1:0] = res1;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// ==== include/acd_pkg.sv ====
// Overview of operation
// - result rate is sample clock over ratio
// - prescale 1/2/4/8 then fixed divide four
// - ratio codes 000..111 give 32..4096
// - ratio resets to 256
// - sinc decimation, nulls at result-rate multiples
// - per-channel 24-bit offset trim applied
// - per-channel 24-bit gain trim applied
// - prescale resets to divide by one
// - low ready pulse one sample period
package acd_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CFG_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFFT0_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] SLOPE0_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] OFFT1_OFS  = 8'h14;
  localparam logic [ADDR_W-1:0] SLOPE1_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] RES0_OFS   = 8'h1c;
  localparam logic [ADDR_W-1:0] RES1_OFS   = 8'h20;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int PRE_LSB = 0;
  localparam int OSR_LSB = 2;
  localparam int EVT_READY = 0;
  localparam int EVT_SAT   = 1;
  localparam int EVT_W     = 2;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [2:0] OSR_RST = 3'h3;
  localparam int TRIM_W = 24;
  // ****************************************
  // timing counts
  // ****************************************
  localparam logic [1:0] SAMPLE_DIV_M1 = 2'h3;
  localparam int OSR_CNT_W = 12;
  localparam int ACC_W = 14;
  localparam logic [4:0] OSR_MIN_SHIFT = 5'h12;
endpackage

// ==== rtl/acd_div.sv ====
`timescale 1ns/10ps
module acd_div #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         en_in,
  input  wire logic [W-1:0] limit,
  output logic              tick
);
  logic [W-1:0] cnt_r;

  // >= so a lowered limit never strands the count above it
  assign tick = en_in && (cnt_r >= limit);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= '0;
    end else if (en_in) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ==== rtl/acd_trim.sv ====
`timescale 1ns/10ps
module acd_trim
  import acd_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              sample_en,
  input  wire logic              dump,
  input  wire logic              bit_in,
  input  wire logic [4:0]        shift,
  input  wire logic [TRIM_W-1:0] offset,
  input  wire logic [TRIM_W-1:0] slope,
  output logic [TRIM_W-1:0]      result_r,
  output logic                   sat_r
);
  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] sum;
  logic signed [25:0]      x;
  logic signed [25:0]      y;
  logic signed [49:0]      p;
  logic signed [26:0]      z;
  logic                    hi;
  logic                    lo;

  // ****************************************
  // sinc1: boxcar over one ratio window
  // ****************************************
  assign sum = acc_r + (bit_in ? ACC_W'(1) : -ACC_W'(1));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      acc_r <= '0;
    end else if (sample_en) begin
      acc_r <= dump ? '0 : sum;
    end
  end

  // ****************************************
  // scale to full range, then trims
  // ****************************************
  assign x  = 26'(signed'(sum)) <<< shift;
  assign y  = x + 26'(signed'(offset));
  assign p  = y * signed'(slope);
  // gain word is a fraction of unity, 1 + g/2^23
  assign z  = 27'(y) + 27'(p >>> 23);
  assign hi = z > 27'sh07fffff;
  assign lo = z < -27'sh0800000;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      result_r <= '0;
      sat_r    <= 1'b0;
    end else begin
      sat_r <= sample_en && dump && (hi || lo);
      if (sample_en && dump) begin
        result_r <= hi ? 24'h7fffff : (lo ? 24'h800000 : z[23:0]);
      end
    end
  end
endmodule

// ==== tb/acd_chk.sv ====
`timescale 1ns/10ps
// ***
// rate chain checker
// ***
module acd_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        modulator_clk,
  input wire logic        sample_clk,
  input wire logic        result_rate_clk,
  input wire logic        result_ready_n
);
  logic [1:0]  pre_r;
  logic [2:0]  osr_r;
  logic        clean_r;
  logic [3:0]  mgap_r;
  logic [2:0]  mcnt_r;
  logic [11:0] scnt_r;
  wire logic   res = sample_clk && result_rate_clk;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // spacing only judged once a whole window ran under one setting
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pre_r <= 2'h0;
      osr_r <= 3'h3;
      clean_r <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      pre_r <= reg_wdata[1:0];
      osr_r <= reg_wdata[4:2];
      clean_r <= 1'b0;
    end else if (res) begin
      clean_r <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    mgap_r <= modulator_clk ? 4'h0 : mgap_r + 4'h1;
    mcnt_r <= sample_clk ? 3'h0 : mcnt_r + {2'h0, modulator_clk};
    scnt_r <= res ? 12'h0 : scnt_r + {11'h0, sample_clk};
  end
  a_rate_in_sample: assert property (result_rate_clk |-> sample_clk)
    else $error("rate pulse off sample");
  a_sample_gap: assert property (sample_clk |=> !sample_clk [*3])
    else $error("sample too close");
  a_mod_spacing: assert property (modulator_clk && clean_r |-> mgap_r == (4'h1 << pre_r) - 4'h1)
    else $error("modulator spacing");
  a_quarter_rate: assert property (sample_clk && clean_r |-> mcnt_r == 3'h3)
    else $error("sample not every fourth");
  a_ratio_period: assert property (res && clean_r |-> scnt_r == (12'h20 << osr_r) - 12'h1)
    else $error("ratio period");
  a_ready_fall: assert property (res |=> $fell(result_ready_n))
    else $error("ready did not fall");
  a_ready_cause: assert property ($fell(result_ready_n) |-> $past(res))
    else $error("ready without result");
  a_ready_rise: assert property (!result_ready_n && sample_clk |=> result_ready_n)
    else $error("ready too long");
  a_ready_hold: assert property (!result_ready_n && !sample_clk |=> !result_ready_n)
    else $error("ready too short");
  c_result: cover property (res);
  c_ready: cover property ($fell(result_ready_n));
  c_cfg: cover property (reg_wr && reg_addr == 8'h00);
endmodule
bind acd_top acd_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .modulator_clk(modulator_clk),
  .sample_clk(sample_clk), .result_rate_clk(result_rate_clk), .result_ready_n(result_ready_n));

// ==== tb/acd_host.sv ====
`timescale 1ns/10ps
// ***
// host interrupt pin
// ***
module acd_host (
  input wire logic  clk_sys,
  input wire logic  rstn,
  input wire logic  result_ready_n,
  output logic [15:0] irq_cnt
);
  logic prev_r;
  // edge counted, as a host pin; a level would merge close pulses
  always_ff @(posedge clk_sys) begin
    prev_r <= result_ready_n;
    if (!rstn) irq_cnt <= 16'h0;
    else if (prev_r && !result_ready_n) irq_cnt <= irq_cnt + 16'h1;
  end
endmodule

// ==== tb/acd_top_bench.sv ====
`timescale 1ns/10ps
module acd_top_bench;
  logic        clk_sys, rstn, reg_wr, reg_rd, mod_bit0, mod_bit1;
  logic        modulator_clk, sample_clk, result_rate_clk, result_ready_n, irq;
  logic        irq_exp, pend, rdy_prev, fix;
  logic [1:0]  pre;
  logic [7:0]  reg_addr;
  logic [15:0] irq_cnt, seen;
  logic [31:0] reg_wdata, reg_rdata, rq[$], pq[$];
  int          err_count, checks_done, gap, lim;
  acd_top uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit0(mod_bit0),
    .mod_bit1(mod_bit1), .modulator_clk(modulator_clk), .sample_clk(sample_clk),
    .result_rate_clk(result_rate_clk), .result_ready_n(result_ready_n), .irq(irq));
  acd_host host (.clk_sys(clk_sys), .rstn(rstn), .result_ready_n(result_ready_n),
    .irq_cnt(irq_cnt));
  task check(input string what, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task final_report;
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task wait_fall;
    seen = irq_cnt;
    lim = 0;
    while (irq_cnt == seen && lim < 40000) begin
      @(posedge clk_sys);
      lim++;
    end
    if (lim >= 40000) begin
      err_count++;
      final_report;
    end
  endtask
  // ***
  // monitor
  // ***
  always @(negedge clk_sys) begin
    if (pend) check("rdata", reg_rdata, rq.pop_front());
    pend = reg_rd;
    gap++;
    if (rdy_prev && !result_ready_n) begin
      check("irq", {31'h0, irq}, {31'h0, irq_exp});
      if (pq.size() > 0) check("period", gap, pq.pop_front());
      gap = 0;
    end
    rdy_prev = result_ready_n;
  end
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    // longest legal run is about 80k cycles
    repeat (90000) @(posedge clk_sys);
    err_count++;
    final_report;
  end
  always @(posedge clk_sys) begin
    mod_bit0 <= fix ? 1'b1 : 1'($urandom);
    mod_bit1 <= fix ? 1'b0 : 1'($urandom);
  end
  // ***
  // stimulus
  // ***
  initial begin
    void'($urandom(89580));
    {rstn, reg_wr, reg_rd, irq_exp, pend} = 5'h0;
    fix = 1'b1;
    {reg_addr, reg_wdata, gap, err_count, checks_done} = '0;
    rdy_prev = 1'b1;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h00, 32'h0000000c);
    rd(8'hfc, 32'h0);
    wr(8'h08, 32'h1);
    for (int i = 0; i < 4; i++) wr(8'h0c + 8'(4 * i), $urandom);
    // fixed bits give full scale, so known trims give known words
    wr(8'h0c, 32'h00ffffff);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h00400000);
    wr(8'h18, 32'h00400000);
    irq_exp = 1'b1;
    wait_fall;
    pq.push_back(32'd1024);
    wait_fall;
    rd(8'h1c, 32'h007fffff);
    rd(8'h20, 32'h00a00000);
    fix = 1'b0;
    wr(8'h04, 32'h1);
    @(negedge clk_sys) check("irq clear", {31'h0, irq}, 32'h0);
    irq_exp = 1'b0;
    wr(8'h08, 32'h0);
    // slow codes keep prescale one so the run stays short
    for (int c = 0; c < 8; c++) begin
      pre = (c < 3) ? 2'($urandom_range(3, 0)) : 2'h0;
      wr(8'h00, {27'h0, 3'(c), pre});
      wait_fall;
      pq.push_back((32'd128 << pre) << c);
      wait_fall;
    end
    final_report;
  end
endmodule
